// ==== src/acl_cfg.svh ====
// constants for the packet classifier: rule word layout, key layout, register map, timing
// assumes word-addressed avalon-mm access and a 25 MHz clock
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH

`define RULE_WORDS   32
`define KEY_WORDS    14
`define KEY_BITS     448
`define W_MASK       14
`define W_ORNG       28
`define W_IRNG       29
`define W_ACT        30
`define W_CTRL       31

`define C_EN         0
`define C_PERMIT     1
`define C_KIND       2
`define C_QEN        4
`define C_Q          5
`define C_REDIR      8
`define C_MIRROR     9
`define C_LOG        10
`define C_TEN        11
`define C_TIDX       12
`define C_DIR        15
`define C_BVLAN      16
`define C_BIND       20

`define K_SRC        128
`define K_IPCP       324
`define K_ETYPE      330

`define A_CNT        10'h100
`define A_REJECT     10'h180
`define A_LOGGED     10'h181
`define A_TIME       10'h182
`define A_MIRROR     10'h183

`define ETYPE_IPV4   16'h0800
`define ETYPE_IPV6   16'h86dd
`define ETYPE_MIN    16'h0600
`define VLAN_MAX     12'hfff

`define LOG_INTERVAL_S 64'd300
`define CLK_HZ         64'd25000000

`endif

// ==== src/acl_pkg.sv ====
// types shared by the packet classifier
// assumes acl_cfg.svh for numeric constants
package acl_pkg;
  typedef enum logic [1:0] {
    kind_l2       = 2'b00,
    kind_ipv4_ext = 2'b01,
    kind_ipv4_std = 2'b10,
    kind_ipv6     = 2'b11
  } kind_t;
endpackage

// ==== src/acl_packet_classifier.sv ====
// access list classifier: rule table, first-match action, hit counters, periodic log report
// assumes a frame header parser on the same clock and an avalon-mm master with word addresses
`timescale 1ns/1ps
`include "acl_cfg.svh"
`default_nettype none

module acl_packet_classifier #(
  parameter int          NUM_RULES    = 8,
  parameter int          NUM_TC       = 8,
  parameter int          LOG_COUNTERS = 4,
  parameter logic [63:0] LOG_CYCLES   = `LOG_INTERVAL_S * `CLK_HZ
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [9:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic         f_valid,
  input  wire logic         f_dir,
  input  wire logic [11:0]  f_port,
  input  wire logic [1:0]   f_tags,
  input  wire logic [11:0]  f_vlan,
  input  wire logic [2:0]   f_pcp,
  input  wire logic [11:0]  f_ivlan,
  input  wire logic [2:0]   f_ipcp,
  input  wire logic [47:0]  f_dmac,
  input  wire logic [47:0]  f_smac,
  input  wire logic [15:0]  f_etype,
  input  wire logic [7:0]   f_proto,
  input  wire logic [15:0]  f_sport,
  input  wire logic [15:0]  f_dport,
  input  wire logic [7:0]   f_tos,
  input  wire logic [19:0]  f_flow,
  input  wire logic [127:0] f_src,
  input  wire logic [127:0] f_dst,
  output logic              r_valid,
  output logic              r_drop,
  output logic              r_rule_hit,
  output logic      [2:0]   r_rule,
  output logic              r_queue_en,
  output logic      [2:0]   r_queue,
  output logic              r_redirect_en,
  output logic      [11:0]  r_redirect_port,
  output logic              r_mirror_en,
  output logic      [11:0]  r_mirror_port,
  output logic              log_valid,
  output logic      [2:0]   log_rule,
  output logic      [15:0]  log_hits
);

  localparam int MEM_WORDS = NUM_RULES * `RULE_WORDS;

  if (NUM_RULES < 1 || NUM_RULES > 8 || NUM_TC < 1 || NUM_TC > 8 || LOG_COUNTERS < 0 ||
      LOG_COUNTERS > NUM_RULES || LOG_CYCLES < 64'd2) begin : g_param_check
    $error("acl_packet_classifier: unsupported parameter values");
  end

  logic [31:0]          mem [MEM_WORDS];
  logic [31:0]          cnt [2*NUM_RULES];
  logic [15:0]          ihit [NUM_RULES];
  logic [15:0]          snap [NUM_RULES];
  logic [NUM_RULES-1:0] rejected;
  logic [NUM_RULES-1:0] logged;
  logic [NUM_RULES-1:0] pend;
  logic [7:0]           time_act;
  logic [11:0]          mirror_port;
  logic [63:0]          tick;
  logic                 interval_end;

  logic [NUM_RULES-1:0] live;
  logic [NUM_RULES-1:0] hit;
  logic                 found;
  logic                 any_live;
  logic [2:0]           first;
  logic [31:0]          first_ctrl;

  logic [`KEY_BITS-1:0] fkey;
  logic [`KEY_BITS-1:0] std_mask;
  logic                 bus_wr;
  logic [2:0]           wr_rule;
  logic                 wr_ctrl;
  logic                 wr_reject;
  logic [15:0]          wr_etype_val;
  logic [15:0]          wr_etype_msk;
  logic [31:0]          wr_old_ctrl;
  logic [31:0]          next_readdata;
  logic [2:0]           log_pick;

  assign fkey     = {6'h00, f_dmac, f_smac, f_etype, f_pcp, f_ipcp, f_proto, f_sport, f_dport,
                     f_tos, f_flow, f_src, f_dst};
  assign std_mask = {{(`KEY_BITS-`K_SRC-32){1'b0}}, 32'hffffffff, {`K_SRC{1'b0}}};

  // per-rule match, all rules in parallel
  for (genvar r = 0; r < NUM_RULES; r++) begin : g_rule
    logic [`KEY_BITS-1:0] val;
    logic [`KEY_BITS-1:0] msk;
    logic [`KEY_BITS-1:0] eff_msk;
    logic [31:0]          ctrl;
    logic [31:0]          orng;
    logic [31:0]          irng;
    acl_pkg::kind_t       kind;
    logic                 etype_ok;
    logic                 outer_ok;
    logic                 inner_used;
    logic                 inner_ok;
    logic                 bind_ok;
    logic                 time_ok;

    for (genvar w = 0; w < `KEY_WORDS; w++) begin : g_word
      assign val[w*32 +: 32] = mem[r*`RULE_WORDS + w];
      assign msk[w*32 +: 32] = mem[r*`RULE_WORDS + `W_MASK + w];
    end

    assign ctrl = mem[r*`RULE_WORDS + `W_CTRL];
    assign orng = mem[r*`RULE_WORDS + `W_ORNG];
    assign irng = mem[r*`RULE_WORDS + `W_IRNG];
    assign kind = acl_pkg::kind_t'(ctrl[`C_KIND +: 2]);

    // standard lists compare only the source address bits of the key; etype, vlan ranges, binding and time gating still apply
    assign eff_msk = (kind == acl_pkg::kind_ipv4_std) ? (msk & std_mask) : msk;

    // zero mask bits are wildcards, so an absent qualifier matches anything
    always_comb begin
      unique case (kind)
        acl_pkg::kind_l2:  etype_ok = 1'b1;
        acl_pkg::kind_ipv6: etype_ok = (f_etype == `ETYPE_IPV6);
        default:           etype_ok = (f_etype == `ETYPE_IPV4);
      endcase
    end

    assign outer_ok   = (f_vlan >= orng[11:0]) && (f_vlan <= orng[27:16]);
    assign inner_used = !(irng[11:0] == 12'h000 && irng[27:16] == `VLAN_MAX) ||
                        (msk[`K_IPCP +: 3] != 3'h0);
    assign inner_ok   = !inner_used ||
                        (f_tags == 2'd2 && f_ivlan >= irng[11:0] && f_ivlan <= irng[27:16]);
    assign bind_ok    = ctrl[`C_BVLAN] ? (f_vlan == ctrl[`C_BIND +: 12])
                                       : (f_port == ctrl[`C_BIND +: 12]);
    assign time_ok    = !ctrl[`C_TEN] || time_act[ctrl[`C_TIDX +: 3]];

    assign live[r] = ctrl[`C_EN] && bind_ok && (ctrl[`C_DIR] == f_dir);
    assign hit[r]  = live[r] && time_ok && etype_ok && outer_ok && inner_ok &&
                     (((fkey ^ val) & eff_msk) == {`KEY_BITS{1'b0}});
  end

  // lowest index wins
  always_comb begin
    found = 1'b0;
    first = 3'h0;
    for (int i = NUM_RULES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        found = 1'b1;
        first = 3'(i);
      end
    end
    any_live   = |live;
    first_ctrl = mem[{first, 5'h1f}];
  end

  // frame decision, one cycle after f_valid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_valid         <= 1'b0;
      r_drop          <= 1'b0;
      r_rule_hit      <= 1'b0;
      r_rule          <= 3'h0;
      r_queue_en      <= 1'b0;
      r_queue         <= 3'h0;
      r_redirect_en   <= 1'b0;
      r_redirect_port <= 12'h000;
      r_mirror_en     <= 1'b0;
      r_mirror_port   <= 12'h000;
    end else begin
      r_valid         <= f_valid;
      r_rule_hit      <= f_valid && found;
      r_rule          <= first;
      r_queue         <= first_ctrl[`C_Q +: 3];
      r_redirect_port <= mem[{first, 5'h1e}][11:0];
      r_mirror_port   <= mirror_port;
      if (f_valid && found) begin
        r_drop        <= !first_ctrl[`C_PERMIT];
        r_queue_en    <= first_ctrl[`C_PERMIT] && first_ctrl[`C_QEN];
        r_redirect_en <= first_ctrl[`C_PERMIT] && first_ctrl[`C_REDIR];
        r_mirror_en   <= first_ctrl[`C_PERMIT] && first_ctrl[`C_MIRROR];
      end else begin
        // no list bound: normal forwarding; bound but unmatched: implicit deny
        r_drop        <= f_valid && any_live;
        r_queue_en    <= 1'b0;
        r_redirect_en <= 1'b0;
        r_mirror_en   <= 1'b0;
      end
    end
  end

  // bus slave: one wait cycle per access, read data registered at the request edge
  assign bus_wr       = avs_write && !avs_waitrequest;
  assign wr_rule      = avs_address[7:5];
  assign wr_ctrl      = (avs_address < 10'(MEM_WORDS)) && (avs_address[4:0] == 5'(`W_CTRL));
  assign wr_old_ctrl  = mem[{wr_rule, 5'h1f}];
  assign wr_etype_val = mem[{wr_rule, 5'(`K_ETYPE / 32)}][`K_ETYPE % 32 +: 16];
  assign wr_etype_msk = mem[{wr_rule, 5'(`W_MASK + `K_ETYPE / 32)}][`K_ETYPE % 32 +: 16];
  // fields must be written before the control word; the check looks at stored values
  assign wr_reject    = avs_writedata[`C_EN] &&
                        ((avs_writedata[`C_MIRROR] && avs_writedata[`C_REDIR]) ||
                         (avs_writedata[`C_KIND +: 2] == 2'b00 && wr_etype_msk != 16'h0000 &&
                          wr_etype_val < `ETYPE_MIN) ||
                         (avs_writedata[`C_QEN] && 32'(avs_writedata[`C_Q +: 3]) >= NUM_TC));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    if (avs_address < 10'(MEM_WORDS)) begin
      next_readdata = mem[avs_address[7:0]];
    end else if (avs_address >= `A_CNT && avs_address < `A_CNT + 10'(2*NUM_RULES)) begin
      next_readdata = cnt[avs_address[3:0]];
    end else if (avs_address == `A_REJECT) begin
      next_readdata = 32'(rejected);
    end else if (avs_address == `A_LOGGED) begin
      next_readdata = 32'(logged);
    end else if (avs_address == `A_TIME) begin
      next_readdata = {24'h000000, time_act};
    end else if (avs_address == `A_MIRROR) begin
      next_readdata = {20'h00000, mirror_port};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= 32'h00000000;
      end
    end else if (bus_wr && avs_address < 10'(MEM_WORDS)) begin
      // a rejected rule is stored but stays unapplied
      mem[avs_address[7:0]] <= (wr_ctrl && wr_reject) ? {avs_writedata[31:1], 1'b0}
                                                      : avs_writedata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rejected <= '0;
      logged   <= '0;
    end else if (bus_wr && wr_ctrl) begin
      rejected[wr_rule] <= wr_reject;
      if (!avs_writedata[`C_EN] || wr_reject) begin
        logged[wr_rule] <= 1'b0;
      end else if (!wr_old_ctrl[`C_EN]) begin
        // counters are only handed out at apply time; an unlogged rule still acts
        logged[wr_rule] <= avs_writedata[`C_LOG] &&
                           ($countones(logged) < LOG_COUNTERS);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      time_act    <= 8'h00;
      mirror_port <= 12'h000;
    end else if (bus_wr) begin
      if (avs_address == `A_TIME) begin
        time_act <= avs_writedata[7:0];
      end
      if (avs_address == `A_MIRROR) begin
        mirror_port <= avs_writedata[11:0];
      end
    end
  end

  // hit counters per rule and direction; a hit in the clearing cycle survives as 1
  for (genvar c = 0; c < 2*NUM_RULES; c++) begin : g_cnt
    logic inc;
    logic clr;
    assign inc = f_valid && found && (first == 3'(c / 2)) && (f_dir == 1'(c % 2));
    assign clr = bus_wr && (avs_address == `A_CNT + 10'(c));
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt[c] <= 32'h00000000;
      end else if (clr) begin
        cnt[c] <= {31'h00000000, inc};
      end else if (inc) begin
        cnt[c] <= cnt[c] + 32'h00000001;
      end
    end
  end

  // logging interval
  assign interval_end = (tick == LOG_CYCLES - 64'd1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick <= 64'd0;
    end else begin
      tick <= interval_end ? 64'd0 : tick + 64'd1;
    end
  end

  for (genvar r = 0; r < NUM_RULES; r++) begin : g_ihit
    logic inc;
    assign inc = f_valid && found && (first == 3'(r));
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        ihit[r] <= 16'h0000;
        snap[r] <= 16'h0000;
      end else if (interval_end) begin
        snap[r] <= ihit[r];
        ihit[r] <= {15'h0000, inc};
      end else if (inc && ihit[r] != 16'hffff) begin
        // saturates rather than wrapping to a false zero
        ihit[r] <= ihit[r] + 16'h0001;
      end
    end
  end

  always_comb begin
    log_pick = 3'h0;
    for (int i = NUM_RULES - 1; i >= 0; i--) begin
      if (pend[i]) begin
        log_pick = 3'(i);
      end
    end
  end

  // one report per cycle, lowest rule first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend      <= '0;
      log_valid <= 1'b0;
      log_rule  <= 3'h0;
      log_hits  <= 16'h0000;
    end else begin
      log_valid <= 1'b0;
      if (interval_end) begin
        for (int i = 0; i < NUM_RULES; i++) begin
          pend[i] <= logged[i] && (ihit[i] != 16'h0000);
        end
      end else if (pend != '0) begin
        pend[log_pick] <= 1'b0;
        log_valid      <= 1'b1;
        log_rule       <= log_pick;
        log_hits       <= snap[log_pick];
      end
    end
  end

endmodule // acl_packet_classifier

`default_nettype wire

// ==== testbench/acl_packet_classifier_asserts.sv ====
// port checker for the packet classifier: bus handshake, verdict timing and sanity, log report
// assumes one clock domain and the tick counter starting from reset like the design's own
`timescale 1ns/1ps
`default_nettype none
module acl_packet_classifier_chk #(
  parameter int          NUM_RULES  = 8,
  parameter int          NUM_TC     = 8,
  parameter logic [63:0] LOG_CYCLES = 64'd1000
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        f_valid,
  input wire logic        r_valid,
  input wire logic        r_drop,
  input wire logic        r_queue_en,
  input wire logic [2:0]  r_queue,
  input wire logic        r_redirect_en,
  input wire logic        r_mirror_en,
  input wire logic        log_valid,
  input wire logic [2:0]  log_rule,
  input wire logic [15:0] log_hits
);
  logic [63:0] tick;
  // one slack cycle in the window, the report start is only pinned to the interval end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) tick <= 64'h0;
    else tick <= (tick == LOG_CYCLES - 64'd1) ? 64'h0 : tick + 64'd1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  a_result_latency: assert property (f_valid |=> r_valid)
    else $error("no verdict one cycle after a frame");
  a_result_idle: assert property (!f_valid |=> !r_valid)
    else $error("verdict without a frame");
  a_deny_no_action: assert property (r_valid && r_drop |-> !(r_queue_en || r_redirect_en || r_mirror_en))
    else $error("dropped frame carries an action");
  a_mirror_redirect: assert property (r_valid |-> !(r_mirror_en && r_redirect_en))
    else $error("mirror and redirect together");
  a_queue_range: assert property (r_valid && r_queue_en |-> {29'h0, r_queue} < NUM_TC)
    else $error("queue index out of range");
  a_log_nonzero: assert property (log_valid |-> log_hits != 16'h0)
    else $error("log entry with zero hits");
  a_log_order: assert property (log_valid && $past(log_valid) |-> log_rule > $past(log_rule))
    else $error("log entries not lowest rule first");
  a_log_window: assert property (log_valid |-> tick <= 64'(NUM_RULES) + 64'd1)
    else $error("log entry outside the report window");
endmodule // acl_packet_classifier_chk
bind acl_packet_classifier acl_packet_classifier_chk #(.NUM_RULES(NUM_RULES), .NUM_TC(NUM_TC),
  .LOG_CYCLES(LOG_CYCLES)) chk (.*);
`default_nettype wire

// ==== testbench/egress_sched_model.sv ====
// egress scheduler stand-in: takes each verdict of the classifier and keeps the latest one
// assumes the result ports on the same clock; idle result fields are masked as meaningless
`timescale 1ns/1ps
`default_nettype none
module egress_sched_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        r_valid,
  input  wire logic        r_drop,
  input  wire logic        r_rule_hit,
  input  wire logic [2:0]  r_rule,
  input  wire logic        r_queue_en,
  input  wire logic [2:0]  r_queue,
  input  wire logic        r_redirect_en,
  input  wire logic [11:0] r_redirect_port,
  input  wire logic        r_mirror_en,
  output logic      [31:0] verdict
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      verdict <= 32'h0;
    end else if (r_valid) begin
      verdict <= {9'h0, r_drop, r_rule_hit, r_rule & {3{r_rule_hit}}, r_queue_en, r_queue & {3{r_queue_en}},
                  r_redirect_en, r_mirror_en, r_redirect_port & {12{r_redirect_en}}};
    end
  end
endmodule // egress_sched_model
`default_nettype wire

// ==== testbench/acl_packet_classifier_tb.sv ====
// self-checking bench: rules over avalon-mm, random frames, counters, logging, time gating
// assumes word addresses, one wait cycle per access and all rules ingress, bound to port 5 except rule 7 on vlan 0x010
`timescale 1ns/1ps
`include "acl_cfg.svh"
`default_nettype none
module acl_packet_classifier_tb;
  logic         clk, rst_b, avs_read, avs_write, avs_waitrequest, f_valid, f_dir;
  logic         r_valid, r_drop, r_rule_hit, r_queue_en, r_redirect_en, r_mirror_en, log_valid, hit;
  logic [1:0]   f_tags;
  logic [2:0]   f_pcp, f_ipcp, r_rule, r_queue, log_rule;
  logic [7:0]   f_proto, f_tos;
  logic [9:0]   avs_address;
  logic [11:0]  f_port, f_vlan, f_ivlan, r_redirect_port, r_mirror_port;
  logic [15:0]  f_etype, f_sport, f_dport, log_hits;
  logic [19:0]  f_flow;
  logic [31:0]  avs_writedata, avs_readdata, verdict, q;
  logic [47:0]  f_dmac, f_smac;
  logic [63:0]  t;
  logic [127:0] f_src, f_dst;
  logic [447:0] k, v0, m0, mm;
  int           mismatches, comparisons, cyc, h0, h1, n;
  int           seed = 32'h0a3c089a;
  acl_packet_classifier #(.LOG_COUNTERS(1), .LOG_CYCLES(64'd1000)) dut (.*);
  egress_sched_model partner (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test;
    end
  end
  task automatic check_reg(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic check_verdict(input logic [31:0] e);
    check_reg(verdict, e);
  endtask
  // request held until waitrequest is seen low; only the global cycle ceiling ends a hang
  task automatic bus(input logic wr_n, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr_n;
    avs_read <= !wr_n;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check_reg(q, e);
  endtask
  // field words before the control word, so a rule never goes live half written
  task automatic prog(input logic [4:0] r, input logic [447:0] v, input logic [447:0] m, input logic [31:0] c);
    for (int i = 0; i < 14; i++) begin
      wr({r, 5'(i)}, v[i*32+:32]);
      wr({r, 5'(i + 14)}, m[i*32+:32]);
    end
    wr({r, 5'd28}, 32'h0fff0000);
    wr({r, 5'd29}, 32'h0fff0000);
    wr({r, 5'd30}, 32'h00000abc);
    wr({r, 5'd31}, c);
  endtask
  task automatic send(input logic [447:0] key);
    @(posedge clk);
    {f_dmac, f_smac, f_etype, f_pcp, f_ipcp, f_proto, f_sport, f_dport, f_tos, f_flow, f_src, f_dst} <= key[441:0];
    f_valid <= 1'b1;
    @(posedge clk);
    f_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] vd(input logic dr, input logic ht, input logic [2:0] ru, input logic qe,
                                     input logic [2:0] qu, input logic re, input logic mi);
    return {9'h0, dr, ht, ru, qe, qu, re, mi, re ? 12'habc : 12'h000};
  endfunction
  initial begin
    {rst_b, avs_read, avs_write, f_valid, f_dir} = 5'b0;
    avs_address = 10'h0;
    avs_writedata = 32'h0;
    f_port = 12'h005;
    f_tags = 2'd1;
    f_vlan = 12'h010;
    f_ivlan = 12'h020;
    {f_dmac, f_smac, f_etype, f_pcp, f_ipcp, f_proto, f_sport, f_dport, f_tos, f_flow, f_src, f_dst} = 442'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rdc(`A_REJECT, 32'h0);
    rdc(`A_CNT, 32'h0);
    rdc(10'h3ff, 32'h0);
    $display("test reset done");
    for (int j = 0; j < 14; j++) v0[j*32+:32] = $random(seed);
    t = {$random(seed), $random(seed)};
    m0 = '0;
    m0[393:346] = t[47:0];
    prog(5'd0, v0, m0, 32'h00500573);
    prog(5'd1, 448'h0, 448'h0, 32'h00500451);
    prog(5'd2, 448'h0, 448'h0, 32'h00500303);
    k = '0;
    mm = '0;
    mm[345:330] = 16'hffff;
    k[345:330] = 16'h05ff;
    prog(5'd3, k, mm, 32'h00500003);
    k[345:330] = `ETYPE_MIN;
    prog(5'd6, k, mm, 32'h00500001);
    rdc(`A_REJECT, 32'h0000000c);
    rdc(`A_LOGGED, 32'h00000001);
    h0 = 0;
    h1 = 0;
    for (int i = 0; i < 40; i++) begin
      for (int j = 0; j < 14; j++) k[j*32+:32] = $random(seed);
      if (i % 2 == 1) k = (k & ~m0) | (v0 & m0);
      hit = ((k ^ v0) & m0) == 448'h0;
      h0 += hit;
      h1 += !hit;
      send(k);
      q = hit ? vd(1'b0, 1'b1, 3'd0, 1'b1, 3'd3, 1'b1, 1'b0)
              : vd(1'b1, 1'b1, 3'd1, 1'b0, 3'd0, 1'b0, 1'b0);
      check_verdict(q);
    end
    send(v0);
    rdc(`A_CNT, 32'(h0 + 1));
    rdc(`A_CNT + 10'h2, 32'(h1));
    n = 0;
    while (log_valid !== 1'b1 && n < 1100) begin
      @(posedge clk);
      n++;
    end
    check_reg({31'h0, log_valid}, 32'h1);
    check_reg({29'h0, log_rule}, 32'h0);
    check_reg({16'h0, log_hits}, 32'(h0 + 1));
    $display("test frames done");
    wr(`A_CNT, 32'h0);
    rdc(`A_CNT, 32'h0);
    wr(10'd31, 32'h0);
    rdc(`A_LOGGED, 32'h0);
    wr(10'd63, 32'h0);
    wr(10'd63, 32'h00500451);
    rdc(`A_LOGGED, 32'h2);
    wr(10'd63, 32'h0);
    prog(5'd4, 448'h0, 448'h0, 32'h00502807);
    wr(`A_TIME, 32'h4);
    k = '0;
    k[345:330] = `ETYPE_IPV4;
    send(k);
    check_verdict(vd(1'b0, 1'b1, 3'd4, 1'b0, 3'd0, 1'b0, 1'b0));
    k[345:330] = `ETYPE_IPV6;
    send(k);
    check_verdict(vd(1'b1, 1'b0, 3'd0, 1'b0, 3'd0, 1'b0, 1'b0));
    prog(5'd5, 448'h0, 448'h0, 32'h00500203);
    wr(`A_MIRROR, 32'h077);
    wr(`A_TIME, 32'h0);
    k[345:330] = `ETYPE_IPV4;
    send(k);
    check_verdict(vd(1'b0, 1'b1, 3'd5, 1'b0, 3'd0, 1'b0, 1'b1));
    check_reg({20'h0, r_mirror_port}, 32'h00000077);
    // vlan-bound ipv6 rule with an inner range: single-tagged frames from another port must miss
    prog(5'd7, 448'h0, 448'h0, 32'h0101000f);
    wr(10'd253, 32'h00200020);
    @(posedge clk);
    f_port <= 12'h009;
    k[345:330] = `ETYPE_IPV6;
    send(k);
    check_verdict(vd(1'b1, 1'b0, 3'd0, 1'b0, 3'd0, 1'b0, 1'b0));
    @(posedge clk);
    f_tags <= 2'd2;
    send(k);
    check_verdict(vd(1'b0, 1'b1, 3'd7, 1'b0, 3'd0, 1'b0, 1'b0));
    // egress frames see no bound rule, so they pass untouched
    @(posedge clk);
    f_dir <= 1'b1;
    f_port <= 12'h005;
    send(k);
    check_verdict(vd(1'b0, 1'b0, 3'd0, 1'b0, 3'd0, 1'b0, 1'b0));
    rdc(`A_CNT + 10'he, 32'h1);
    rdc(`A_CNT + 10'hf, 32'h0);
    $display("test policy done");
    stop_test;
  end
endmodule // acl_packet_classifier_tb
`default_nettype wire
